// ### bench/dac_serial_control_logic_bench.sv
// Self-checking bench: host model drives frames, the bench drives load, clear and reset pins.
// Assumes twos complement format, so the output shows the code with its MSB flipped, except after control write 00012 selects offset binary.
`timescale 1ns/1ps
`define CHECK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module dac_serial_control_logic_bench;
   localparam dac_ctrl_pkg::data_t MSB = dac_ctrl_pkg::CODE_MSB;
   logic clk, rst_b, load_output_n, clear_output_n, device_reset_n;
   logic frame_select_n, serial_clock, serial_data_in, readback_data_out, readback_data_out_en_n;
   logic output_ground_clamp, output_tristate, output_buffer_bypass, rb_done;
   logic [19:0] output_code;
   dac_ctrl_pkg::frame_t rb_word;
   dac_ctrl_pkg::data_t code_q[$], last_code, exp_code, val, clr_val;
   dac_ctrl_pkg::frame_t rb_q[$], exp_rb;
   int error_cnt = 0;
   int checks = 0;
   int seed = 5;
   dac_serial_control_logic dac_serial_control_logic_i (.clk(clk), .rst_b(rst_b),
      .frame_select_n(frame_select_n), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .load_output_n(load_output_n), .clear_output_n(clear_output_n), .device_reset_n(device_reset_n),
      .readback_data_out(readback_data_out), .readback_data_out_en_n(readback_data_out_en_n),
      .output_code(output_code), .output_ground_clamp(output_ground_clamp),
      .output_tristate(output_tristate), .output_buffer_bypass(output_buffer_bypass));
   host_serial_model host_serial_model_i (.clk(clk), .readback_data_out(readback_data_out),
      .readback_data_out_en_n(readback_data_out_en_n), .frame_select_n(frame_select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in), .rb_word(rb_word), .rb_done(rb_done));
   task automatic finish_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic frame(input dac_ctrl_pkg::frame_t f, input logic watch, input dac_ctrl_pkg::frame_t e);
      if (watch) rb_q.push_back(e);
      host_serial_model_i.send(f, 24, watch);
   endtask
   task automatic wr(input dac_ctrl_pkg::addr_t a, input dac_ctrl_pkg::data_t d);
      host_serial_model_i.send({1'b0, a, d}, 24, 1'b0);
   endtask
   task automatic settle;
      for (int i = 0; i < 40 && code_q.size() != 0; i++) @(posedge clk);
      if (code_q.size() != 0) begin
         error_cnt++;
         finish_test();
      end
      repeat (20) @(posedge clk);
   endtask
   // Every change of the output code must match the oldest expected note; a change with none is wrong.
   always @(negedge clk) begin
      if (rst_b && output_code !== last_code) begin
         exp_code = last_code;
         if (code_q.size() != 0) exp_code = code_q.pop_front();
         `CHECK("output_code", exp_code, output_code)
         last_code = output_code;
      end
      if (rb_done && rb_q.size() != 0) begin
         exp_rb = rb_q.pop_front();
         `CHECK("readback", exp_rb, rb_word)
      end
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      rst_b = 1'b0;
      load_output_n = 1'b1;
      clear_output_n = 1'b1;
      device_reset_n = 1'b1;
      last_code = MSB;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(negedge clk);
      `CHECK("clamp", 1'b1, output_ground_clamp)
      `CHECK("bypass", 1'b1, output_buffer_bypass)
      `CHECK("rb_en_n", 1'b1, readback_data_out_en_n)
      frame({1'b1, dac_ctrl_pkg::ADDR_CONTROL, 20'h00000}, 1'b0, '0);
      frame({1'b1, dac_ctrl_pkg::ADDR_CLEAR, 20'h00000}, 1'b1,
            {1'b1, dac_ctrl_pkg::ADDR_CONTROL, dac_ctrl_pkg::CTRL_RESET});
      frame({1'b1, dac_ctrl_pkg::ADDR_CODE, 20'h00000}, 1'b1,
            {1'b1, dac_ctrl_pkg::ADDR_CLEAR, dac_ctrl_pkg::CLEAR_RESET});
      frame({1'b0, dac_ctrl_pkg::ADDR_NO_OPERATION, 20'hFFFFF}, 1'b1,
            {1'b1, dac_ctrl_pkg::ADDR_CODE, dac_ctrl_pkg::CODE_RESET});
      frame({1'b1, dac_ctrl_pkg::ADDR_NO_OPERATION, 20'hABCDE}, 1'b0, '0);
      @(posedge clk) load_output_n <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         val = 20'($random(seed));
         code_q.push_back(val ^ MSB);
         wr(dac_ctrl_pkg::ADDR_CODE, val);
         settle();
      end
      frame({1'b1, dac_ctrl_pkg::ADDR_CODE, 20'h00000}, 1'b0, '0);
      frame({1'b0, dac_ctrl_pkg::ADDR_NO_OPERATION, 20'h00000}, 1'b1, {1'b1, dac_ctrl_pkg::ADDR_CODE, val});
      wr(dac_ctrl_pkg::ADDR_CONTROL, 20'h00006);
      `CHECK("tristate", 1'b1, output_tristate)
      wr(dac_ctrl_pkg::ADDR_CONTROL, 20'h00022);
      `CHECK("clamp", 1'b0, output_ground_clamp)
      `CHECK("tristate", 1'b0, output_tristate)
      frame({1'b1, dac_ctrl_pkg::ADDR_CONTROL, 20'h00000}, 1'b0, '0);
      frame({1'b0, dac_ctrl_pkg::ADDR_NO_OPERATION, 20'h00000}, 1'b1, 24'hAAAAAA);
      host_serial_model_i.send({1'b0, dac_ctrl_pkg::ADDR_CODE, ~val}, 23, 1'b0);
      host_serial_model_i.send({1'b0, dac_ctrl_pkg::ADDR_CODE, ~val}, 25, 1'b0);
      repeat (20) @(posedge clk);
      val = 20'($random(seed));
      code_q.push_back(val ^ MSB);
      wr(dac_ctrl_pkg::ADDR_CODE, val);
      settle();
      @(posedge clk) load_output_n <= 1'b1;
      val = 20'($random(seed));
      wr(dac_ctrl_pkg::ADDR_CODE, val);
      repeat (20) @(posedge clk);
      code_q.push_back(val ^ MSB);
      @(posedge clk) load_output_n <= 1'b0;
      settle();
      @(posedge clk) load_output_n <= 1'b1;
      clr_val = 20'($random(seed));
      wr(dac_ctrl_pkg::ADDR_CLEAR, clr_val);
      code_q.push_back(clr_val ^ MSB);
      @(posedge clk) clear_output_n <= 1'b0;
      settle();
      val = 20'($random(seed));
      @(posedge clk) load_output_n <= 1'b0;
      wr(dac_ctrl_pkg::ADDR_CODE, val);
      @(posedge clk) load_output_n <= 1'b1;
      @(posedge clk) clear_output_n <= 1'b1;
      repeat (30) @(posedge clk);
      code_q.push_back(val ^ MSB);
      @(posedge clk) load_output_n <= 1'b0;
      settle();
      code_q.push_back(clr_val ^ MSB);
      wr(dac_ctrl_pkg::ADDR_ACTIONS, 20'h00002);
      settle();
      code_q.push_back(clr_val);
      wr(dac_ctrl_pkg::ADDR_CONTROL, 20'h00012);
      settle();
      code_q.push_back(MSB);
      wr(dac_ctrl_pkg::ADDR_ACTIONS, 20'h00004);
      settle();
      `CHECK("clamp", 1'b1, output_ground_clamp)
      val = 20'($random(seed));
      code_q.push_back(val ^ MSB);
      wr(dac_ctrl_pkg::ADDR_CODE, val);
      settle();
      code_q.push_back(MSB);
      @(posedge clk) device_reset_n <= 1'b0;
      settle();
      wr(dac_ctrl_pkg::ADDR_CODE, ~val);
      @(posedge clk) device_reset_n <= 1'b1;
      repeat (30) @(posedge clk);
      `CHECK("clamp", 1'b1, output_ground_clamp)
      finish_test();
   end
endmodule

// ### bench/dac_serial_control_logic_sva.sv
// Port-level assertions for the converter serial control logic.
// Assumes pins move slowly next to clk and reach the block through its own synchronisers.
`timescale 1ns/1ps
module dac_serial_control_logic_sva #(
   parameter int DATA_WIDTH = 20
) (
   input wire logic                  clk,
   input wire logic                  rst_b,
   input wire logic                  frame_select_n,
   input wire logic                  serial_clock,
   input wire logic                  serial_data_in,
   input wire logic                  load_output_n,
   input wire logic                  clear_output_n,
   input wire logic                  device_reset_n,
   input wire logic                  readback_data_out,
   input wire logic                  readback_data_out_en_n,
   input wire logic [DATA_WIDTH-1:0] output_code,
   input wire logic                  output_ground_clamp,
   input wire logic                  output_tristate,
   input wire logic                  output_buffer_bypass
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_reset_defaults: assert property (
      $rose(rst_b) |-> output_code == dac_ctrl_pkg::CODE_MSB && output_ground_clamp && output_tristate
         && output_buffer_bypass && readback_data_out_en_n) else $error("defaults wrong after reset");
   a_pin_reset_hold: assert property (
      (!device_reset_n) [*8] |-> output_code == dac_ctrl_pkg::CODE_MSB && output_ground_clamp)
      else $error("device reset pin did not hold defaults");
   a_clamp_over_tri: assert property (
      output_ground_clamp |-> output_tristate) else $error("clamp did not force tristate");
   a_release_readback: assert property (
      frame_select_n [*6] |-> readback_data_out_en_n) else $error("readback driven outside a frame");
   a_enable_in_frame: assert property (
      $fell(readback_data_out_en_n) |-> !frame_select_n) else $error("readback enabled without a frame");
   a_clear_blocks: assert property (
      (!clear_output_n) [*8] |-> $stable(output_code)) else $error("output changed while clear held");
   a_frame_quiet: assert property (
      (!frame_select_n && clear_output_n && device_reset_n && $stable(load_output_n)) [*8]
         |-> $stable(output_code)) else $error("output changed inside a frame");
   a_readback_still: assert property (
      (!serial_clock && !frame_select_n) [*8] |-> $stable(readback_data_out))
      else $error("readback bit moved without a serial clock rise");
endmodule
bind dac_serial_control_logic dac_serial_control_logic_sva #(.DATA_WIDTH(DATA_WIDTH)) sva_i (
   .clk(clk), .rst_b(rst_b), .frame_select_n(frame_select_n), .serial_clock(serial_clock),
   .serial_data_in(serial_data_in), .load_output_n(load_output_n), .clear_output_n(clear_output_n),
   .device_reset_n(device_reset_n), .readback_data_out(readback_data_out),
   .readback_data_out_en_n(readback_data_out_en_n), .output_code(output_code),
   .output_ground_clamp(output_ground_clamp), .output_tristate(output_tristate),
   .output_buffer_bypass(output_buffer_bypass));

// ### bench/host_serial_model.sv
// Host serial master: sends frames of any edge count and gathers the readback word.
// Assumes clk is the bench clock; the serial clock is 8 clk periods and idles low.
`timescale 1ns/1ps
module host_serial_model (
   input  wire logic                  clk,
   input  wire logic                  readback_data_out,
   input  wire logic                  readback_data_out_en_n,
   output logic                       frame_select_n,
   output logic                       serial_clock,
   output logic                       serial_data_in,
   output dac_ctrl_pkg::frame_t       rb_word,
   output logic                       rb_done
);
   initial begin
      frame_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_data_in = 1'b0;
      rb_word = '0;
      rb_done = 1'b0;
   end
   task automatic send(input dac_ctrl_pkg::frame_t f, input int edges, input logic watch);
      dac_ctrl_pkg::frame_t got;
      got = '0;
      @(posedge clk) frame_select_n <= 1'b0;
      repeat (10) @(posedge clk);
      for (int k = 0; k < edges; k++) begin
         serial_clock <= 1'b1;
         serial_data_in <= (k < 24) ? f[23-k] : f[0];
         repeat (4) @(posedge clk);
         serial_clock <= 1'b0;
         repeat (4) @(posedge clk);
         // A released readback line is read as the inverse of the last bit.
         got = {got[22:0], readback_data_out_en_n ? ~got[0] : readback_data_out};
      end
      frame_select_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      rb_word <= got;
      rb_done <= watch;
      @(posedge clk) rb_done <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule

// ### core/dac_ctrl_pkg.sv
// Constants shared by the serial control logic of the 20-bit output converter.
// Assumes every user writes package::name and imports nothing.
package dac_ctrl_pkg;

   localparam int FRAME_BITS = 24;
   localparam int DATA_BITS  = 20;
   localparam int ADDR_BITS  = 3;
   localparam int RW_POS     = 23;
   localparam int ADDR_HI    = 22;
   localparam int ADDR_LO    = 20;
   localparam int COUNT_BITS = 5;

   typedef logic [ADDR_BITS-1:0]  addr_t;
   typedef logic [DATA_BITS-1:0]  data_t;
   typedef logic [FRAME_BITS-1:0] frame_t;
   typedef logic [COUNT_BITS-1:0] count_t;

   localparam addr_t ADDR_NO_OPERATION = 3'h0;
   localparam addr_t ADDR_CODE         = 3'h1;
   localparam addr_t ADDR_CONTROL      = 3'h2;
   localparam addr_t ADDR_CLEAR        = 3'h3;
   localparam addr_t ADDR_ACTIONS      = 3'h4;

   localparam count_t COUNT_FULL  = 5'h18;
   localparam count_t COUNT_LIMIT = 5'h19;

   // Operating control register fields.
   localparam int CTRL_BUFFER_POS   = 1;
   localparam int CTRL_CLAMP_POS    = 2;
   localparam int CTRL_TRISTATE_POS = 3;
   localparam int CTRL_FORMAT_POS   = 4;
   localparam int CTRL_RB_OFF_POS   = 5;
   localparam data_t CTRL_RESET      = 20'h0000E;
   localparam data_t CTRL_WRITE_MASK = 20'h0003E;

   localparam data_t CODE_RESET  = 20'h00000;
   localparam data_t CLEAR_RESET = 20'h00000;
   localparam data_t CODE_MSB    = 20'h80000;

   // Software action register fields.
   localparam int ACT_CLEAR_POS = 1;
   localparam int ACT_RESET_POS = 2;

   // Pin positions in the synchronised input vector.
   localparam int PIN_SELECT = 0;
   localparam int PIN_SCLK   = 1;
   localparam int PIN_SDI    = 2;
   localparam int PIN_LOAD   = 3;
   localparam int PIN_CLEAR  = 4;
   localparam int PIN_RESET  = 5;
   localparam int PIN_COUNT  = 6;
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h39;

endpackage

// ### core/dac_serial_control_logic.sv
// Serial control logic of a 20-bit voltage-output converter: frame decoding,
// register file, readback, load, clear and reset pins.
// Assumes all pins are asynchronous to clk and the serial clock is well below clk/3.
// Operation
// - Frames are 24 bits, shifted MSB first on the serial clock.
// - Bit 23 is read flag, bits 22-20 address, bits 19-0 payload.
// - Address zero does nothing, read or write.
// - Writes go to code, control, clear value and software action registers.
// - Reads select code, control or clear value register.
// - A falling frame select starts a frame.
// - Frames with other than 24 falling edges are discarded.
// - Rising frame select latches the frame and moves payload to its register.
// - The frame after a read shifts that register out on readback data.
// - Readback pin released while frame select is high.
// - Readback is pipelined; next frame carries previous read's data.
// - Readback drives only when enabled; enabled after reset.
// - Load held low in the frame updates output at select rise.
// - Load held high defers update to load's falling edge after select rise.
// - Reset pin low holds defaults; programming ignored until release.
// - Software reset action restores the power-on state.
// - Clear low loads code from clear value and blocks new updates.
// - After clear, output keeps clear value until a new code is loaded.
// - Software clear action equals the clear pin.
// - Clear value resets to zero and follows the selected code format.
// - Ground clamp resets set and overrides the tristate bit.
// - Format bit resets zero for twos complement; one is offset binary.
`timescale 1ns/1ps
module dac_serial_control_logic #(
   parameter int DATA_WIDTH = 20
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  frame_select_n,
   input  wire logic                  serial_clock,
   input  wire logic                  serial_data_in,
   input  wire logic                  load_output_n,
   input  wire logic                  clear_output_n,
   input  wire logic                  device_reset_n,
   output logic                       readback_data_out,
   output logic                       readback_data_out_en_n,
   output logic [DATA_WIDTH-1:0]      output_code,
   output logic                       output_ground_clamp,
   output logic                       output_tristate,
   output logic                       output_buffer_bypass
);

   typedef enum logic [0:0] {
      UPD_IDLE,
      UPD_ARMED
   } update_state_e;

   if (DATA_WIDTH != dac_ctrl_pkg::DATA_BITS) begin : g_check
      $error("DATA_WIDTH must match the 20-bit payload of the frame");
   end

   logic [dac_ctrl_pkg::PIN_COUNT-1:0] pins;
   logic                               select_s;
   logic                               sclk_s;
   logic                               sdi_s;
   logic                               load_s;
   logic                               clear_s;
   logic                               reset_s;

   dac_ctrl_pkg::frame_t shift_reg;
   dac_ctrl_pkg::frame_t next_shift_reg;
   dac_ctrl_pkg::count_t bit_count;
   dac_ctrl_pkg::count_t next_bit_count;
   dac_ctrl_pkg::data_t  pending_code;
   dac_ctrl_pkg::data_t  next_pending_code;
   dac_ctrl_pkg::data_t  converter_code;
   dac_ctrl_pkg::data_t  next_converter_code;
   dac_ctrl_pkg::data_t  operating_control;
   dac_ctrl_pkg::data_t  next_operating_control;
   dac_ctrl_pkg::data_t  clear_value;
   dac_ctrl_pkg::data_t  next_clear_value;
   dac_ctrl_pkg::addr_t  read_addr;
   dac_ctrl_pkg::addr_t  next_read_addr;
   logic                 read_armed;
   logic                 next_read_armed;
   logic                 load_high_seen;
   logic                 next_load_high_seen;
   logic                 soft_reset;
   logic                 next_soft_reset;
   logic                 soft_clear;
   logic                 next_soft_clear;
   logic                 prev_select;
   logic                 prev_sclk;
   logic                 prev_load;
   logic                 drive_n;
   logic                 next_drive_n;
   update_state_e        upd_state;
   update_state_e        next_upd_state;

   logic                 frame_fall;
   logic                 frame_rise;
   logic                 sclk_fall;
   logic                 sclk_rise;
   logic                 load_fall;
   logic                 resetting;
   logic                 clearing;
   logic                 frame_valid;
   logic                 rb_load;
   logic                 rb_shift;
   dac_ctrl_pkg::frame_t rb_word;
   dac_ctrl_pkg::addr_t  frame_addr;
   dac_ctrl_pkg::data_t  payload;
   logic                 frame_read;

   pin_synchronizer #(
      .WIDTH       (dac_ctrl_pkg::PIN_COUNT),
      .RESET_VALUE (dac_ctrl_pkg::PIN_IDLE)
   ) pin_synchronizer_i (
      .clk      (clk),
      .rst_b    (rst_b),
      .pin_in   ({device_reset_n, clear_output_n, load_output_n,
                  serial_data_in, serial_clock, frame_select_n}),
      .pin_sync (pins)
   );

   assign select_s = pins[dac_ctrl_pkg::PIN_SELECT];
   assign sclk_s   = pins[dac_ctrl_pkg::PIN_SCLK];
   assign sdi_s    = pins[dac_ctrl_pkg::PIN_SDI];
   assign load_s   = pins[dac_ctrl_pkg::PIN_LOAD];
   assign clear_s  = pins[dac_ctrl_pkg::PIN_CLEAR];
   assign reset_s  = pins[dac_ctrl_pkg::PIN_RESET];

   assign frame_fall = prev_select & ~select_s;
   assign frame_rise = ~prev_select & select_s;
   assign sclk_fall  = prev_sclk & ~sclk_s & ~select_s;
   assign sclk_rise  = ~prev_sclk & sclk_s & ~select_s;
   assign load_fall  = prev_load & ~load_s;
   assign resetting  = ~reset_s | soft_reset;
   assign clearing   = ~clear_s | soft_clear;
   assign frame_valid = frame_rise && (bit_count == dac_ctrl_pkg::COUNT_FULL);
   assign frame_read  = shift_reg[dac_ctrl_pkg::RW_POS];
   assign frame_addr  = shift_reg[dac_ctrl_pkg::ADDR_HI:dac_ctrl_pkg::ADDR_LO];
   assign payload     = shift_reg[dac_ctrl_pkg::DATA_BITS-1:0];

   // Readback word: echoes the read request as header over the register data.
   function automatic dac_ctrl_pkg::frame_t read_word(input dac_ctrl_pkg::addr_t addr,
                                                      input dac_ctrl_pkg::data_t code,
                                                      input dac_ctrl_pkg::data_t ctrl,
                                                      input dac_ctrl_pkg::data_t clr);
      dac_ctrl_pkg::data_t value;
      case (addr)
         dac_ctrl_pkg::ADDR_CODE:    value = code;
         dac_ctrl_pkg::ADDR_CONTROL: value = ctrl;
         dac_ctrl_pkg::ADDR_CLEAR:   value = clr;
         default:                    value = '0;
      endcase
      return {1'b1, addr, value};
   endfunction

   readback_shifter #(
      .WIDTH (dac_ctrl_pkg::FRAME_BITS)
   ) readback_shifter_i (
      .clk     (clk),
      .rst_b   (rst_b),
      .load    (rb_load),
      .word    (rb_word),
      .shift   (rb_shift),
      .bit_out (readback_data_out)
   );

   always_comb begin
      next_shift_reg         = shift_reg;
      next_bit_count         = bit_count;
      next_pending_code      = pending_code;
      next_converter_code    = converter_code;
      next_operating_control = operating_control;
      next_clear_value       = clear_value;
      next_read_addr         = read_addr;
      next_read_armed        = read_armed;
      next_load_high_seen    = load_high_seen;
      next_soft_reset        = 1'b0;
      next_soft_clear        = 1'b0;
      next_upd_state         = upd_state;
      rb_load                = 1'b0;
      rb_shift               = 1'b0;
      rb_word                = '0;

      if (frame_fall) begin
         next_bit_count      = '0;
         next_load_high_seen = load_s;
         rb_load             = 1'b1;
         next_read_armed     = 1'b0;
         if (read_armed) begin
            rb_word = read_word(read_addr, converter_code, operating_control, clear_value);
         end
      end else if (sclk_fall) begin
         next_shift_reg = {shift_reg[dac_ctrl_pkg::FRAME_BITS-2:0], sdi_s};
         if (bit_count != dac_ctrl_pkg::COUNT_LIMIT) begin
            next_bit_count = bit_count + 5'h01;
         end
      end
      if (sclk_rise && bit_count != '0) begin
         rb_shift = 1'b1;
      end
      if (!select_s && load_s) begin
         next_load_high_seen = 1'b1;
      end

      // A pending code goes out before frame decode, so a write landing on a load edge re-arms.
      if (upd_state == UPD_ARMED && load_fall && select_s && !clearing) begin
         next_converter_code = pending_code;
         next_upd_state      = UPD_IDLE;
      end

      if (frame_valid) begin
         if (frame_read) begin
            if (frame_addr != dac_ctrl_pkg::ADDR_NO_OPERATION) begin
               next_read_addr  = frame_addr;
               next_read_armed = 1'b1;
            end
         end else begin
            case (frame_addr)
               dac_ctrl_pkg::ADDR_CODE: begin
                  next_pending_code = payload;
                  if (!load_high_seen && !load_s && !clearing) begin
                     next_converter_code = payload;
                     next_upd_state      = UPD_IDLE;
                  end else begin
                     next_upd_state = UPD_ARMED;
                  end
               end
               dac_ctrl_pkg::ADDR_CONTROL: begin
                  next_operating_control = payload & dac_ctrl_pkg::CTRL_WRITE_MASK;
               end
               dac_ctrl_pkg::ADDR_CLEAR: begin
                  next_clear_value = payload;
               end
               dac_ctrl_pkg::ADDR_ACTIONS: begin
                  next_soft_reset = payload[dac_ctrl_pkg::ACT_RESET_POS];
                  next_soft_clear = payload[dac_ctrl_pkg::ACT_CLEAR_POS];
               end
               default: begin
               end
            endcase
         end
      end

      if (clearing) begin
         next_converter_code = clear_value;
      end

      if (resetting) begin
         next_pending_code      = dac_ctrl_pkg::CODE_RESET;
         next_converter_code    = dac_ctrl_pkg::CODE_RESET;
         next_operating_control = dac_ctrl_pkg::CTRL_RESET;
         next_clear_value       = dac_ctrl_pkg::CLEAR_RESET;
         next_read_armed        = 1'b0;
         next_soft_clear        = 1'b0;
         next_upd_state         = UPD_IDLE;
      end

      next_drive_n = select_s | resetting
                     | next_operating_control[dac_ctrl_pkg::CTRL_RB_OFF_POS];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg         <= '0;
         bit_count         <= '0;
         pending_code      <= dac_ctrl_pkg::CODE_RESET;
         converter_code    <= dac_ctrl_pkg::CODE_RESET;
         operating_control <= dac_ctrl_pkg::CTRL_RESET;
         clear_value       <= dac_ctrl_pkg::CLEAR_RESET;
         read_addr         <= dac_ctrl_pkg::ADDR_NO_OPERATION;
         read_armed        <= 1'b0;
         load_high_seen    <= 1'b1;
         soft_reset        <= 1'b0;
         soft_clear        <= 1'b0;
         prev_select       <= 1'b1;
         prev_sclk         <= 1'b0;
         prev_load         <= 1'b1;
         drive_n           <= 1'b1;
         upd_state         <= UPD_IDLE;
      end else begin
         shift_reg         <= next_shift_reg;
         bit_count         <= next_bit_count;
         pending_code      <= next_pending_code;
         converter_code    <= next_converter_code;
         operating_control <= next_operating_control;
         clear_value       <= next_clear_value;
         read_addr         <= next_read_addr;
         read_armed        <= next_read_armed;
         load_high_seen    <= next_load_high_seen;
         soft_reset        <= next_soft_reset;
         soft_clear        <= next_soft_clear;
         prev_select       <= select_s;
         prev_sclk         <= sclk_s;
         prev_load         <= load_s;
         drive_n           <= next_drive_n;
         upd_state         <= next_upd_state;
      end
   end

   // The ladder wants offset binary, so twos complement codes flip the MSB.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         output_code          <= dac_ctrl_pkg::CODE_MSB;
         output_ground_clamp  <= 1'b1;
         output_tristate      <= 1'b1;
         output_buffer_bypass <= 1'b1;
      end else begin
         output_code <= operating_control[dac_ctrl_pkg::CTRL_FORMAT_POS]
                        ? converter_code : converter_code ^ dac_ctrl_pkg::CODE_MSB;
         output_ground_clamp  <= operating_control[dac_ctrl_pkg::CTRL_CLAMP_POS];
         output_tristate      <= operating_control[dac_ctrl_pkg::CTRL_CLAMP_POS]
                                 | operating_control[dac_ctrl_pkg::CTRL_TRISTATE_POS];
         output_buffer_bypass <= operating_control[dac_ctrl_pkg::CTRL_BUFFER_POS];
      end
   end

   assign readback_data_out_en_n = drive_n;

endmodule

// ### core/pin_synchronizer.sv
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes every bit is independent; no bus coherence is promised.
`timescale 1ns/1ps
module pin_synchronizer #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] stage_one;

   if (WIDTH < 1) begin : g_check
      $error("pin_synchronizer needs WIDTH of at least one");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            stage_one[i] <= RESET_VALUE[i];
            pin_sync[i]  <= RESET_VALUE[i];
         end else begin
            stage_one[i] <= pin_in[i];
            pin_sync[i]  <= stage_one[i];
         end
      end
   end

endmodule

// ### core/readback_shifter.sv
// Parallel-load shift register that presents its word MSB first.
// Assumes load and shift are never requested in the same cycle; load wins.
`timescale 1ns/1ps
module readback_shifter #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] word,
   input  wire logic             shift,
   output logic                  bit_out
);

   logic [WIDTH-1:0] shift_word;
   logic [WIDTH-1:0] next_shift_word;

   if (WIDTH < 2) begin : g_check
      $error("readback_shifter needs WIDTH of at least two");
   end

   always_comb begin
      next_shift_word = shift_word;
      if (load) begin
         next_shift_word = word;
      end else if (shift) begin
         next_shift_word = {shift_word[WIDTH-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_word <= '0;
      end else begin
         shift_word <= next_shift_word;
      end
   end

   assign bit_out = shift_word[WIDTH-1];

endmodule
